// *** design/bst_defines.svh ***
// Constants of the boundary-scan test access port
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

// Register lengths
`define BST_IR_LEN 3
`define BST_ID_LEN 32
`define BST_BSR_LEN 16

// Output-bus enable cell in the boundary chain, preset high
`define BST_BSR_OE_BIT 15
`define BST_BSR_RST 16'h8000

// Pattern loaded into the instruction shifter at capture
`define BST_IR_CAPTURE 3'h1

// Instruction codes
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE_Z 3'h2
`define BST_OP_SAMPLE 3'h4
`define BST_OP_BYPASS 3'h7

// Identification code, value is arbitrary, bit 0 set
`define BST_IDCODE_VAL 32'h0a5a5001

`endif

// *** design/bst_pkg.sv ***
// Types of the boundary-scan test access port
package bst_pkg;
`include "bst_defines.svh"

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR,
    ST_UPD_IR
  } bst_state_e;

  typedef struct packed {
    bst_state_e state;
    logic [`BST_IR_LEN-1:0] ir_sh;
    logic [`BST_IR_LEN-1:0] ir;
    logic [`BST_ID_LEN-1:0] id_sh;
    logic [`BST_BSR_LEN-1:0] bsr_sh;
    logic [`BST_BSR_LEN-1:0] bsr_upd;
    logic byp;
    logic [`BST_BSR_LEN-1:0] pin_s1;
    logic [`BST_BSR_LEN-1:0] pin_s2;
    logic out_drive;
    logic out_hiz;
    logic upd_tgl;
  } bst_tck_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } bst_neg_s;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic drive;
    logic hiz;
    logic [`BST_BSR_LEN-1:0] data;
    logic tms_pu;
    logic tdi_pu;
  } bst_mclk_s;

endpackage

// *** design/bst_tap.sv ***
// Boundary-scan test access port with its scan registers
// Notes on behaviour
// - Port follows the 1149.1 state machine and instruction handling.
// - TAP controller plus instruction, boundary, bypass and ID registers.
// - Mode select and data input are pulled up when left open.
// - Power-up starts in reset, which leaves memory operation alone.
// - Every test input is captured at the rising test-clock edge.
// - Every test output is launched at the falling test-clock edge.
// - Mode select, sampled at rising edges, steers the state transitions.
// - The current instruction picks the register between data in and out.
// - Serial input enters the selected register at its top bit.
// - Serial output presents the lowest bit of the selected register.
// - Output driver is enabled only in the two shift states.
// - Five rising edges with mode select high reach reset from anywhere.
// - A test reset never disturbs memory traffic.
// - Power-up reset leaves the serial output in high impedance.
// - Three-bit instruction register holds the ID instruction after reset.
// - Instruction capture loads binary 01 into the two low bits.
// - Bypass is one bit, cleared at capture, a one-stage path.
// - ID instruction captures the fixed 32-bit code and shifts it out.
`timescale 1ns/1ps

module bst_tap
  import bst_pkg::*;
(
  // Memory clock and power-up reset
  input wire logic mclk,
  input wire logic reset,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // Pad pull-up requests for mode select and data input
  output logic tms_pullup,
  output logic tdi_pullup,
  // Boundary cells facing the memory pins
  input wire logic [`BST_BSR_LEN-1:0] pins_in,
  output logic [`BST_BSR_LEN-1:0] bs_data,
  output logic bs_drive,
  output logic bs_hiz
);
  import bst_pkg::*;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam bst_tck_s TCK_RST = '{
    state: ST_TLR,
    ir: `BST_OP_IDCODE,
    bsr_upd: `BST_BSR_RST,
    default: '0
  };
  localparam bst_neg_s NEG_RST = '{
    tdo: 1'b0,
    tdo_oe_n: 1'b1
  };
  localparam bst_mclk_s MCLK_RST = '{
    tms_pu: 1'b1,
    tdi_pu: 1'b1,
    default: '0
  };

  bst_tck_s t_q;
  bst_tck_s t_d;
  bst_neg_s n_q;
  bst_neg_s n_d;
  bst_mclk_s m_q;
  bst_mclk_s m_d;

  // ----------------------------------------------------------------
  // Register selection by instruction
  // ----------------------------------------------------------------
  function automatic logic sel_bsr(input logic [`BST_IR_LEN-1:0] op);
    sel_bsr = (op == `BST_OP_EXTEST) || (op == `BST_OP_SAMPLE) ||
              (op == `BST_OP_SAMPLE_Z);
  endfunction

  function automatic logic sel_id(input logic [`BST_IR_LEN-1:0] op);
    sel_id = (op == `BST_OP_IDCODE);
  endfunction

  // ----------------------------------------------------------------
  // Test-clock rising edge: controller and shift registers
  // ----------------------------------------------------------------
  always_comb
  begin
    t_d = t_q;
    t_d.pin_s1 = pins_in;
    t_d.pin_s2 = t_q.pin_s1;
    // Next state from mode select
    case (t_q.state)
      ST_TLR: t_d.state = tms ? ST_TLR : ST_RTI;
      ST_RTI: t_d.state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: t_d.state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: t_d.state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: t_d.state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: t_d.state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: t_d.state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: t_d.state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: t_d.state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: t_d.state = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: t_d.state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: t_d.state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: t_d.state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: t_d.state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: t_d.state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: t_d.state = tms ? ST_SEL_DR : ST_RTI;
      default: t_d.state = ST_TLR;
    endcase
    // Work done in the current state
    case (t_q.state)
      ST_CAP_IR:
      begin
        t_d.ir_sh = `BST_IR_CAPTURE;
      end
      ST_SH_IR:
      begin
        t_d.ir_sh = {tdi, t_q.ir_sh[`BST_IR_LEN-1:1]};
      end
      ST_UPD_IR:
      begin
        t_d.ir = t_q.ir_sh;
        t_d.upd_tgl = ~t_q.upd_tgl;
      end
      ST_CAP_DR:
      begin
        if (sel_bsr(t_q.ir))
        begin
          t_d.bsr_sh = t_q.pin_s2;
        end
        else if (sel_id(t_q.ir))
        begin
          t_d.id_sh = `BST_IDCODE_VAL;
        end
        else
        begin
          t_d.byp = 1'b0;
        end
      end
      ST_SH_DR:
      begin
        if (sel_bsr(t_q.ir))
        begin
          t_d.bsr_sh = {tdi, t_q.bsr_sh[`BST_BSR_LEN-1:1]};
        end
        else if (sel_id(t_q.ir))
        begin
          t_d.id_sh = {tdi, t_q.id_sh[`BST_ID_LEN-1:1]};
        end
        else
        begin
          t_d.byp = tdi;
        end
      end
      ST_UPD_DR:
      begin
        if (sel_bsr(t_q.ir))
        begin
          t_d.bsr_upd = t_q.bsr_sh;
          t_d.upd_tgl = ~t_q.upd_tgl;
        end
      end
      default:
      begin
        t_d.byp = t_q.byp;
      end
    endcase
    // Test-logic reset: ID instruction, output-bus enable cell preset
    if (t_d.state == ST_TLR)
    begin
      t_d.ir = `BST_OP_IDCODE;
      t_d.bsr_upd[`BST_BSR_OE_BIT] = 1'b1;
      if (t_q.state != ST_TLR)
      begin
        t_d.upd_tgl = ~t_q.upd_tgl;
      end
    end
    // Memory-side controls follow the active instruction and, under EXTEST, the bus enable cell
    t_d.out_drive = (t_d.ir == `BST_OP_EXTEST);
    t_d.out_hiz = (t_d.ir == `BST_OP_SAMPLE_Z) ||
                  ((t_d.ir == `BST_OP_EXTEST) &&
                   !t_d.bsr_upd[`BST_BSR_OE_BIT]);
  end

  // ----------------------------------------------------------------
  // Test-clock rising edge: state register
  // ----------------------------------------------------------------
  always_ff @(posedge tck or posedge reset)
  begin
    if (reset)
    begin
      t_q <= TCK_RST;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  // ----------------------------------------------------------------
  // Test-clock falling edge: serial output launch
  // ----------------------------------------------------------------
  always_comb
  begin
    n_d = n_q;
    n_d.tdo_oe_n = 1'b1;
    case (t_q.state)
      ST_SH_IR:
      begin
        n_d.tdo = t_q.ir_sh[0];
        n_d.tdo_oe_n = 1'b0;
      end
      ST_SH_DR:
      begin
        if (sel_bsr(t_q.ir))
        begin
          n_d.tdo = t_q.bsr_sh[0];
        end
        else if (sel_id(t_q.ir))
        begin
          n_d.tdo = t_q.id_sh[0];
        end
        else
        begin
          n_d.tdo = t_q.byp;
        end
        n_d.tdo_oe_n = 1'b0;
      end
      default:
      begin
        n_d.tdo = n_q.tdo;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Test-clock falling edge: output register
  // ----------------------------------------------------------------
  always_ff @(negedge tck or posedge reset)
  begin
    if (reset)
    begin
      n_q <= NEG_RST;
    end
    else
    begin
      n_q <= n_d;
    end
  end

  // ----------------------------------------------------------------
  // Memory clock: boundary controls taken over by toggle handshake
  // ----------------------------------------------------------------
  always_comb
  begin
    m_d = m_q;
    m_d.tgl_s1 = t_q.upd_tgl;
    m_d.tgl_s2 = m_q.tgl_s1;
    m_d.tgl_seen = m_q.tgl_s2;
    m_d.tms_pu = 1'b1;
    m_d.tdi_pu = 1'b1;
    if (m_q.tgl_s2 != m_q.tgl_seen)
    begin
      m_d.drive = t_q.out_drive;
      m_d.hiz = t_q.out_hiz;
      m_d.data = t_q.bsr_upd;
    end
  end

  // ----------------------------------------------------------------
  // Memory clock: handshake and output register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      m_q <= MCLK_RST;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial output pin and its enable
  // ----------------------------------------------------------------
  assign tdo = n_q.tdo;
  assign tdo_oe_n = n_q.tdo_oe_n;

  // ----------------------------------------------------------------
  // Pad requests and memory-side outputs
  // ----------------------------------------------------------------
  assign tms_pullup = m_q.tms_pu;
  assign tdi_pullup = m_q.tdi_pu;
  assign bs_data = m_q.data;
  assign bs_drive = m_q.drive;
  assign bs_hiz = m_q.hiz;

endmodule

// *** testbench/bst_tap_asserts.sv ***
// Assertions on the test access port pins
`timescale 1ns/1ps
`include "bst_defines.svh"

module bst_tap_asserts
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic tck,
  // Test port
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic tms_pullup,
  input wire logic tdi_pullup,
  // Boundary side
  input wire logic [`BST_BSR_LEN-1:0] bs_data,
  input wire logic bs_drive,
  input wire logic bs_hiz
);
  AST_PULLUP: assert property (@(posedge mclk) disable iff (reset)
    tms_pullup && tdi_pullup) else $error("pull-up request low");
  AST_PWR_UP: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> tdo_oe_n && !bs_drive && !bs_hiz)
    else $error("outputs active after power-up");
  AST_TDO_FALL: assert property (@(posedge mclk) disable iff (reset)
    $changed(tdo) |-> !tck) else $error("tdo moved off a falling edge");
  AST_OE_FALL: assert property (@(posedge mclk) disable iff (reset)
    $changed(tdo_oe_n) |-> !tck) else $error("enable moved off falling edge");
  AST_STAY_SHIFT: assert property (@(posedge tck) disable iff (reset)
    !tdo_oe_n && !tms |=> !tdo_oe_n) else $error("driver lost in shift");
  AST_LEAVE_SHIFT: assert property (@(posedge tck) disable iff (reset)
    !tdo_oe_n && tms |=> tdo_oe_n) else $error("driver kept after shift");
  AST_TLR_OE: assert property (@(posedge tck) disable iff (reset)
    tms [*5] |=> tdo_oe_n) else $error("driver on after five highs");
  AST_TLR_BS: assert property (@(posedge tck) disable iff (reset)
    tms [*5] |-> ##2 !bs_drive && !bs_hiz)
    else $error("boundary outputs not cleared by test reset");
  AST_HIZ: assert property (@(posedge mclk) disable iff (reset)
    bs_drive |-> bs_hiz == !bs_data[`BST_BSR_OE_BIT])
    else $error("bus enable cell ignored");
endmodule

bind bst_tap bst_tap_asserts bst_tap_asserts_inst (.mclk(mclk), .reset(reset),
  .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .tms_pullup(tms_pullup), .tdi_pullup(tdi_pullup), .bs_data(bs_data),
  .bs_drive(bs_drive), .bs_hiz(bs_hiz));

// *** testbench/bst_jtag_model.sv ***
// Behavioural external test controller
`timescale 1ns/1ps

module bst_jtag_model
(
  // Test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  event rx_ev;
  logic rx;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test-clock period; clock stands low between calls
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #16;
    rx = tdo;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask

  // Scan n bits from idle and return to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    step(1'b1, 1'b1);
    if (ir)
    begin
      step(1'b1, 1'b1);
    end
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      -> rx_ev;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  task automatic tap_reset();
    repeat (5) step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench of the test access port
`timescale 1ns/1ps
`include "bst_defines.svh"

`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] %0t value mismatch", $time); \
    end \
  end

module tb;
  logic mclk, reset, tck, tms, tdi, tdo, tdo_oe_n, tms_pullup, tdi_pullup;
  logic [15:0] pins_in, bs_data, p;
  logic bs_drive, bs_hiz;
  logic [31:0] v;
  logic exp_q[$];
  logic [2:0] codes[4] = '{3'h3, 3'h5, 3'h6, `BST_OP_BYPASS};
  int fails, comparisons;
  // Released data-out line shows the inverse of its last level
  wire tdo_line = tdo_oe_n ? ~tdo : tdo;

  bst_tap bst_tap_inst (.mclk(mclk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tms_pullup(tms_pullup),
    .tdi_pullup(tdi_pullup), .pins_in(pins_in), .bs_data(bs_data),
    .bs_drive(bs_drive), .bs_hiz(bs_hiz));

  bst_jtag_model bst_jtag_model_inst (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo_line));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Each shifted-out bit is compared with the oldest note
  always @(bst_jtag_model_inst.rx_ev)
  begin
    `CHK(bst_jtag_model_inst.rx, exp_q.pop_front())
  end

  task automatic sc(input logic ir, input int n, input logic [31:0] e,
    input logic [31:0] d);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(e[i]);
    end
    bst_jtag_model_inst.scan(ir, n, d);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    pins_in = 16'h0;
    v = $urandom(32'hbbf3fa0e);
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    `CHK(tdo_oe_n, 1'b1)
    `CHK({tms_pullup, tdi_pullup}, 2'h3)
    `CHK({bs_drive, bs_hiz, bs_data}, 18'h0)
    bst_jtag_model_inst.tap_reset();
    foreach (codes[i])
    begin
      sc(1'b1, 3, `BST_IR_CAPTURE, {29'h0, codes[i]});
      v = $urandom;
      sc(1'b0, 8, {v[30:0], 1'b0}, v);
    end
    @(negedge mclk);
    pins_in = v[31:16];
    p = {1'b0, v[14:0]};
    sc(1'b1, 3, `BST_IR_CAPTURE, {29'h0, `BST_OP_SAMPLE});
    sc(1'b0, 16, {16'h0, pins_in}, {16'h0, p});
    sc(1'b1, 3, `BST_IR_CAPTURE, {29'h0, `BST_OP_EXTEST});
    repeat (8) @(negedge mclk);
    `CHK({bs_drive, bs_hiz, bs_data}, {2'h3, p})
    sc(1'b1, 3, `BST_IR_CAPTURE, {29'h0, `BST_OP_SAMPLE_Z});
    repeat (8) @(negedge mclk);
    `CHK({bs_drive, bs_hiz}, 2'h1)
    bst_jtag_model_inst.tap_reset();
    repeat (8) @(negedge mclk);
    `CHK({bs_drive, bs_hiz, bs_data[15]}, 3'h1)
    sc(1'b0, 32, `BST_IDCODE_VAL, 32'h0);
    summarize();
  end
endmodule
